// [rtl/zrp_zero_return.sv]
// zero-return sequencer, pulse shaper and present-position register for one axis
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module zrp_zero_return #(
	parameter bit TWO_AXIS = 1'b1,
	parameter int unsigned CLEAR_CYC = zrp_pkg::CLEAR_WIDTH_US * (zrp_pkg::CLK_HZ / 1_000_000)
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// register port
	input wire zrp_pkg::zrp_bus_s bus_i,
	output logic [31:0] rdata_o,
	// mode and start sources
	input wire logic hand_operation_mode_i,
	input wire logic end_step_standby_i,
	input wire logic home_request_input_i,
	input wire logic home_instruction_i,
	input wire logic subtask_home_request_i,
	input wire logic interp_drive_i,
	// switches and zero pulse
	input wire logic near_point_switch_i,
	input wire logic forward_limit_switch_i,
	input wire logic reverse_limit_switch_i,
	input wire logic zero_point_pulse_i,
	// drive outputs
	output logic fwd_pulse_o,
	output logic rev_pulse_o,
	output logic drive_deviation_clear_output_o,
	output logic home_done_flag_o
);
	initial
	begin
		if (CLEAR_CYC < 1 || CLEAR_CYC > 32'h00ffffff)
			$error("zrp_zero_return: CLEAR_CYC out of range");
	end

	typedef enum logic [2:0] {ST_IDLE, ST_ESCAPE, ST_TRAVEL, ST_SEARCH, ST_DECEL, ST_CREEP, ST_CLEAR} zrp_state_e;

	// register storage
	logic [1:0] run_ff;                    // continuous drive fwd/rev
	logic [zrp_pkg::SPD_W-1:0] home_speed_ff;
	logic [zrp_pkg::SPD_W-1:0] creep_speed_ff;
	logic [zrp_pkg::SPD_W-1:0] drive_speed_ff;
	zrp_pkg::zrp_cfg_s cfg_ff;
	logic [zrp_pkg::POS_W-1:0] home_addr_ff;
	logic [15:0] zero_count_ff;
	logic [15:0] decel_time_ff;
	logic host_req_ff;                     // one-cycle host request
	// sequencer state
	zrp_state_e state_ff;
	logic [zrp_pkg::SPD_W-1:0] freq_ff;    // present output frequency
	logic dir_rev_ff;                      // 1 = reverse pulses
	logic [15:0] zcount_ff;                // zero pulses seen
	logic counting_ff;                     // zero pulse counting open
	logic seen_near_ff;                    // search: switch met on the way back
	logic search_fail_ff;                  // limit hit, no search allowed
	logic [23:0] clr_cnt_ff;
	logic [zrp_pkg::ACC_W-1:0] ramp_acc_ff;
	// pulse shaper
	logic [zrp_pkg::ACC_W-1:0] phase_ff;
	logic [7:0] hi_cnt_ff;
	logic pulse_ff;
	logic pulse_rev_ff;
	logic [zrp_pkg::POS_W-1:0] position_ff;
	// input capture
	logic zp_meta_ff;
	logic zp_sync_ff;
	logic zp_last_ff;
	logic near_last_ff;
	logic req_last_ff;
	logic done_ff;
	logic clr_out_ff;
	logic fwd_ff;                          // registered forward pin
	logic rev_ff;                          // registered reverse pin
	logic [31:0] rdata_ff;

	// polarity-corrected switch levels
	logic near_act;
	logic fwd_lim_act;
	logic rev_lim_act;
	logic lim_ahead;
	logic near_rise;
	logic near_fall;
	logic zp_rise;
	logic req_any;
	logic req_start;
	logic moving;
	logic wrap;
	logic fixed_high;
	logic [zrp_pkg::ACC_W-1:0] phase_sum;
	logic [zrp_pkg::ACC_W-1:0] nxt_phase;
	logic [zrp_pkg::ACC_W-1:0] decel_cyc;
	logic [zrp_pkg::SPD_W-1:0] diff_spd;

	localparam logic [zrp_pkg::ACC_W-1:0] CLK_HZ_W = zrp_pkg::ACC_W'(zrp_pkg::CLK_HZ);
	localparam logic [zrp_pkg::ACC_W-1:0] HALF_W = zrp_pkg::ACC_W'(zrp_pkg::CLK_HZ / 2);
	localparam logic [7:0] FIXED_HIGH_W = 8'(zrp_pkg::FIXED_HIGH_CYC);
	localparam logic [zrp_pkg::SPD_W-1:0] FULL_DUTY_W = zrp_pkg::SPD_W'(zrp_pkg::FULL_DUTY_MAX_HZ);
	localparam logic [zrp_pkg::SPD_W-1:0] MAX_HZ_W = zrp_pkg::SPD_W'(zrp_pkg::MAX_HZ);
	localparam logic [23:0] CLEAR_W = 24'(CLEAR_CYC);
	localparam logic [zrp_pkg::ACC_W-1:0] CYC_MS_W = zrp_pkg::ACC_W'(zrp_pkg::CYC_PER_MS);

	// switch polarity and edges
	always_comb
	begin
		near_act = near_point_switch_i ^ cfg_ff.switch_polarity[zrp_pkg::POL_NEAR];
		fwd_lim_act = forward_limit_switch_i ^ cfg_ff.switch_polarity[zrp_pkg::POL_FWD];
		rev_lim_act = reverse_limit_switch_i ^ cfg_ff.switch_polarity[zrp_pkg::POL_REV];
		lim_ahead = dir_rev_ff ? rev_lim_act : fwd_lim_act;
		near_rise = near_act && !near_last_ff;
		near_fall = !near_act && near_last_ff;
		zp_rise = zp_sync_ff && !zp_last_ff;
		decel_cyc = zrp_pkg::ACC_W'(decel_time_ff * CYC_MS_W);
		diff_spd = (home_speed_ff > creep_speed_ff) ? home_speed_ff - creep_speed_ff : '0;
	end

	// start sources gated by operating mode
	always_comb
	begin
		if (hand_operation_mode_i)
			req_any = home_request_input_i || host_req_ff;
		else
			req_any = ((home_request_input_i || host_req_ff) && end_step_standby_i)
				|| home_instruction_i
				|| subtask_home_request_i;
		req_start = req_any && !req_last_ff && state_ff == ST_IDLE;
	end

	// register writes
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			run_ff <= 2'h0;
			home_speed_ff <= zrp_pkg::HOME_SPEED_RESET;
			creep_speed_ff <= zrp_pkg::CREEP_SPEED_RESET;
			drive_speed_ff <= zrp_pkg::HOME_SPEED_RESET;
			cfg_ff <= zrp_pkg::CFG_RESET;
			home_addr_ff <= '0;
			zero_count_ff <= zrp_pkg::ZERO_COUNT_RESET;
			decel_time_ff <= zrp_pkg::DECEL_TIME_RESET;
			host_req_ff <= 1'b0;
		end
		else
		begin
			host_req_ff <= 1'b0;
			if (bus_i.wr)
			begin
				case (bus_i.addr)
					zrp_pkg::REG_CTRL:
					begin
						run_ff <= {bus_i.wdata[zrp_pkg::CTRL_RUN_REV], bus_i.wdata[zrp_pkg::CTRL_RUN_FWD]};
						host_req_ff <= bus_i.wdata[zrp_pkg::CTRL_HOME_REQ];
					end
					zrp_pkg::REG_HOME_SPEED: home_speed_ff <= bus_i.wdata[zrp_pkg::SPD_W-1:0];
					zrp_pkg::REG_CREEP_SPEED: creep_speed_ff <= bus_i.wdata[zrp_pkg::SPD_W-1:0];
					zrp_pkg::REG_DRIVE_SPEED: drive_speed_ff <= bus_i.wdata[zrp_pkg::SPD_W-1:0];
					zrp_pkg::REG_CONFIG: cfg_ff <= bus_i.wdata[zrp_pkg::CFG_W-1:0];
					zrp_pkg::REG_HOME_ADDR: home_addr_ff <= bus_i.wdata;
					zrp_pkg::REG_ZERO_COUNT: zero_count_ff <= bus_i.wdata[15:0];
					zrp_pkg::REG_DECEL_TIME: decel_time_ff <= bus_i.wdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// register reads, data one cycle after the strobe
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_ff <= 32'h0;
		else if (bus_i.rd)
		begin
			case (bus_i.addr)
				zrp_pkg::REG_CTRL: rdata_ff <= {30'h0, run_ff};
				zrp_pkg::REG_HOME_SPEED: rdata_ff <= 32'(home_speed_ff);
				zrp_pkg::REG_CREEP_SPEED: rdata_ff <= 32'(creep_speed_ff);
				zrp_pkg::REG_DRIVE_SPEED: rdata_ff <= 32'(drive_speed_ff);
				zrp_pkg::REG_CONFIG: rdata_ff <= 32'(cfg_ff);
				zrp_pkg::REG_HOME_ADDR: rdata_ff <= home_addr_ff;
				zrp_pkg::REG_ZERO_COUNT: rdata_ff <= {16'h0, zero_count_ff};
				zrp_pkg::REG_DECEL_TIME: rdata_ff <= {16'h0, decel_time_ff};
				zrp_pkg::REG_STATUS: rdata_ff <= {8'(zcount_ff), 14'h0, 3'(state_ff), search_fail_ff,
					dir_rev_ff, moving, clr_out_ff, done_ff, 2'h0};
				zrp_pkg::REG_POSITION: rdata_ff <= position_ff;
				default: rdata_ff <= 32'h0; // unmapped reads zero
			endcase
		end
		else
			rdata_ff <= 32'h0;
	end

	// input capture: zero pulse synchroniser, edge history
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			zp_meta_ff <= 1'b0;
			zp_sync_ff <= 1'b0;
			zp_last_ff <= 1'b0;
			near_last_ff <= 1'b0;
			req_last_ff <= 1'b0;
		end
		else
		begin
			zp_meta_ff <= zero_point_pulse_i;
			zp_sync_ff <= zp_meta_ff;
			zp_last_ff <= zp_sync_ff;
			near_last_ff <= near_act;
			req_last_ff <= req_any;
		end
	end

	// zero-return sequencer
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= ST_IDLE;
			dir_rev_ff <= 1'b0;
			zcount_ff <= 16'h0;
			counting_ff <= 1'b0;
			seen_near_ff <= 1'b0;
			search_fail_ff <= 1'b0;
			clr_cnt_ff <= 24'h0;
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
				begin
					if (req_start)
					begin
						zcount_ff <= 16'h0;
						counting_ff <= 1'b0;
						search_fail_ff <= 1'b0;
						if (cfg_ff.count_start == zrp_pkg::CNT_NO_SWITCH)
						begin
							clr_cnt_ff <= CLEAR_W;
							state_ff <= ST_CLEAR;
						end
						else if (near_act)
						begin
							dir_rev_ff <= !cfg_ff.home_reverse;
							state_ff <= ST_ESCAPE;
						end
						else
						begin
							dir_rev_ff <= cfg_ff.home_reverse;
							state_ff <= ST_TRAVEL;
						end
					end
					else
						dir_rev_ff <= run_ff[1];
				end
				ST_ESCAPE:
				begin
					// back off the switch, then approach it again
					if (!near_act)
					begin
						dir_rev_ff <= cfg_ff.home_reverse;
						state_ff <= ST_TRAVEL;
					end
				end
				ST_TRAVEL:
				begin
					if (near_rise)
					begin
						counting_ff <= (cfg_ff.count_start == zrp_pkg::CNT_LEADING);
						state_ff <= ST_DECEL;
					end
					else if (lim_ahead)
					begin
						if (cfg_ff.limits_wired)
						begin
							dir_rev_ff <= !cfg_ff.home_reverse;
							seen_near_ff <= 1'b0;
							state_ff <= ST_SEARCH;
						end
						else
						begin
							search_fail_ff <= 1'b1;
							state_ff <= ST_IDLE;
						end
					end
				end
				ST_SEARCH:
				begin
					// run back until the switch is met and left behind
					if (near_rise)
						seen_near_ff <= 1'b1;
					if (seen_near_ff && near_fall)
					begin
						dir_rev_ff <= cfg_ff.home_reverse;
						state_ff <= ST_TRAVEL;
					end
				end
				ST_DECEL, ST_CREEP:
				begin
					if (state_ff == ST_DECEL && freq_ff <= creep_speed_ff)
						state_ff <= ST_CREEP;
					if (!counting_ff && near_fall)
						counting_ff <= 1'b1;
					if (counting_ff && zp_rise)
					begin
						zcount_ff <= zcount_ff + 16'h1;
						if (zcount_ff + 16'h1 >= zero_count_ff)
						begin
							clr_cnt_ff <= CLEAR_W;
							state_ff <= ST_CLEAR;
						end
					end
				end
				ST_CLEAR:
				begin
					// clear time starts once the last pulse has ended
					if (!pulse_ff)
					begin
						if (clr_cnt_ff <= 24'h1)
							state_ff <= ST_IDLE;
						clr_cnt_ff <= clr_cnt_ff - 24'h1;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// output frequency: home speed, linear ramp, creep, or plain drive
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			freq_ff <= '0;
			ramp_acc_ff <= '0;
		end
		else
		begin
			case (state_ff)
				ST_ESCAPE, ST_TRAVEL, ST_SEARCH:
				begin
					freq_ff <= home_speed_ff;
					ramp_acc_ff <= '0;
				end
				ST_DECEL:
				begin
					if (decel_cyc == '0 || freq_ff <= creep_speed_ff)
						freq_ff <= creep_speed_ff;
					else if (ramp_acc_ff + zrp_pkg::ACC_W'(diff_spd) >= decel_cyc)
					begin
						ramp_acc_ff <= ramp_acc_ff + zrp_pkg::ACC_W'(diff_spd) - decel_cyc;
						freq_ff <= freq_ff - 1'b1;
					end
					else
						ramp_acc_ff <= ramp_acc_ff + zrp_pkg::ACC_W'(diff_spd);
				end
				ST_CREEP: freq_ff <= creep_speed_ff;
				ST_IDLE: freq_ff <= (run_ff != 2'h0) ? drive_speed_ff : '0;
				default: freq_ff <= '0; // clear: travel stopped
			endcase
			if (freq_ff > MAX_HZ_W)
				freq_ff <= MAX_HZ_W;
			// a stop lets the running pulse keep its full high time
			if (pulse_ff && (state_ff == ST_CLEAR || (state_ff == ST_IDLE && run_ff == 2'h0)))
				freq_ff <= freq_ff;
		end
	end

	// phase accumulator: one period every CLK_HZ/freq cycles
	always_comb
	begin
		moving = freq_ff != '0;
		phase_sum = phase_ff + zrp_pkg::ACC_W'(freq_ff);
		wrap = moving && phase_sum >= CLK_HZ_W;
		nxt_phase = wrap ? phase_sum - CLK_HZ_W : phase_sum;
		fixed_high = TWO_AXIS && !interp_drive_i && freq_ff > FULL_DUTY_W;
	end

	// pulse shaping
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			phase_ff <= HALF_W;
			hi_cnt_ff <= 8'h0;
			pulse_ff <= 1'b0;
			pulse_rev_ff <= 1'b0;
		end
		else if (!moving)
		begin
			phase_ff <= HALF_W; // first edge one half period after start
			hi_cnt_ff <= 8'h0;
			pulse_ff <= 1'b0;
		end
		else
		begin
			phase_ff <= nxt_phase;
			if (wrap)
			begin
				pulse_rev_ff <= dir_rev_ff;
				hi_cnt_ff <= FIXED_HIGH_W;
			end
			else if (hi_cnt_ff != 8'h0)
				hi_cnt_ff <= hi_cnt_ff - 8'h1;
			if (fixed_high)
				pulse_ff <= wrap || hi_cnt_ff > 8'h1;
			else
				pulse_ff <= wrap || (pulse_ff && nxt_phase < HALF_W);
		end
	end

	// present position: counts own pulses, loaded at home end
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			position_ff <= '0;
		else if (state_ff == ST_CLEAR && clr_cnt_ff == CLEAR_W)
			position_ff <= home_addr_ff;
		else if (wrap)
			position_ff <= dir_rev_ff ? position_ff - 1'b1 : position_ff + 1'b1;
	end

	// done flag and clear output
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			done_ff <= 1'b0;
			clr_out_ff <= 1'b0;
		end
		else
		begin
			clr_out_ff <= state_ff == ST_CLEAR && !pulse_ff;
			if (clr_out_ff && state_ff != ST_CLEAR)
				done_ff <= 1'b1;
			else if (req_start)
				done_ff <= 1'b0;
		end
	end

	// pulse pins from flops, split by direction
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fwd_ff <= 1'b0;
			rev_ff <= 1'b0;
		end
		else
		begin
			fwd_ff <= pulse_ff && !pulse_rev_ff;
			rev_ff <= pulse_ff && pulse_rev_ff;
		end
	end

	assign fwd_pulse_o = fwd_ff;
	assign rev_pulse_o = rev_ff;
	assign drive_deviation_clear_output_o = clr_out_ff;
	assign home_done_flag_o = done_ff;
	assign rdata_o = rdata_ff;
endmodule // zrp_zero_return
`default_nettype wire

// [rtl/zrp_pkg.sv]
// constants, register map and carriers for the zero-return pulse output block
package zrp_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned FIXED_HIGH_NS = 2500;
	localparam int unsigned FIXED_HIGH_CYC = (FIXED_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned FULL_DUTY_MAX_HZ = 100_000;
	localparam int unsigned MAX_HZ = 200_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned CLEAR_WIDTH_US = 1000;
	// widths
	localparam int unsigned SPD_W = 18;
	localparam int unsigned ACC_W = 27;
	localparam int unsigned POS_W = 32;
	// register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_HOME_SPEED = 8'h04;
	localparam logic [7:0] REG_CREEP_SPEED = 8'h08;
	localparam logic [7:0] REG_CONFIG = 8'h0c;
	localparam logic [7:0] REG_HOME_ADDR = 8'h10;
	localparam logic [7:0] REG_ZERO_COUNT = 8'h14;
	localparam logic [7:0] REG_DECEL_TIME = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	localparam logic [7:0] REG_POSITION = 8'h20;
	localparam logic [7:0] REG_DRIVE_SPEED = 8'h24;
	// control bit positions
	localparam int unsigned CTRL_RUN_FWD = 0;
	localparam int unsigned CTRL_RUN_REV = 1;
	localparam int unsigned CTRL_HOME_REQ = 4;
	// count start selections
	localparam logic [1:0] CNT_LEADING = 2'h0;
	localparam logic [1:0] CNT_TRAILING = 2'h1;
	localparam logic [1:0] CNT_NO_SWITCH = 2'h2;
	// configuration word, high bits first
	typedef struct packed {
		logic limits_wired;            // bit 6
		logic [2:0] switch_polarity;   // bits 5:3 rev limit, fwd limit, near; 1 = normally closed
		logic [1:0] count_start;       // bits 2:1
		logic home_reverse;            // bit 0
	} zrp_cfg_s;
	localparam int unsigned CFG_W = 7;
	localparam logic [CFG_W-1:0] CFG_RESET = 7'h41;
	localparam int unsigned POL_NEAR = 0;
	localparam int unsigned POL_FWD = 1;
	localparam int unsigned POL_REV = 2;
	// parameter reset values
	localparam logic [SPD_W-1:0] HOME_SPEED_RESET = 18'h02710;
	localparam logic [SPD_W-1:0] CREEP_SPEED_RESET = 18'h003e8;
	localparam logic [15:0] ZERO_COUNT_RESET = 16'h0001;
	localparam logic [15:0] DECEL_TIME_RESET = 16'h0064;
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} zrp_bus_s;
endpackage

// [tb/zrp_zero_return_chk.sv]
// concurrent checks on the zero-return block ports
`timescale 1ns/1ns
`default_nettype none
module zrp_zero_return_chk #(
	parameter int unsigned CLEAR_CYC = 8
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// drive outputs
	input wire logic fwd_pulse_o,
	input wire logic rev_pulse_o,
	input wire logic drive_deviation_clear_output_o,
	input wire logic home_done_flag_o
);
	logic [15:0] hi_ff; // cycles pulse high
	logic [15:0] lo_ff; // cycles pulse low, saturating
	logic [15:0] clr_ff; // cycles clear high
	wire logic pls = fwd_pulse_o | rev_pulse_o; // either pulse
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// run lengths; low starts full so the first pulse passes
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hi_ff <= 16'h0;
			lo_ff <= 16'hffff;
			clr_ff <= 16'h0;
		end
		else
		begin
			hi_ff <= pls ? hi_ff + 16'h1 : 16'h0;
			lo_ff <= pls ? 16'h0 : ((lo_ff == 16'hffff) ? lo_ff : lo_ff + 16'h1);
			clr_ff <= drive_deviation_clear_output_o ? clr_ff + 16'h1 : 16'h0;
		end
	end
	// end of clear, then done soon after
	sequence s_clr_end;
		$fell(drive_deviation_clear_output_o);
	endsequence
	sequence s_done_soon;
		##[0:2] home_done_flag_o;
	endsequence
	a_pulse_excl: assert property (!(fwd_pulse_o && rev_pulse_o))
		else $error("both pulse outputs high");
	a_high_len: assert property ($fell(pls) |-> hi_ff >= zrp_pkg::FIXED_HIGH_CYC)
		else $error("pulse high too short");
	a_low_len: assert property ($rose(pls) |-> lo_ff >= zrp_pkg::FIXED_HIGH_CYC)
		else $error("pulse low too short");
	a_clear_len: assert property (s_clr_end |-> clr_ff == CLEAR_CYC)
		else $error("clear width wrong");
	a_clear_done: assert property (s_clr_end |-> s_done_soon)
		else $error("done missing after clear");
	a_clear_nodone: assert property (drive_deviation_clear_output_o |-> !home_done_flag_o)
		else $error("done high during clear");
	a_clear_still: assert property (drive_deviation_clear_output_o |-> !pls)
		else $error("pulse during clear");
	a_done_cause: assert property ($rose(home_done_flag_o) |->
		$past(drive_deviation_clear_output_o, 1) || $past(drive_deviation_clear_output_o, 2))
		else $error("done rose without clear");
endmodule // zrp_zero_return_chk
bind zrp_zero_return zrp_zero_return_chk #(.CLEAR_CYC(CLEAR_CYC)) zrp_zero_return_chk_inst (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.fwd_pulse_o(fwd_pulse_o),
	.rev_pulse_o(rev_pulse_o),
	.drive_deviation_clear_output_o(drive_deviation_clear_output_o),
	.home_done_flag_o(home_done_flag_o)
);
`default_nettype wire

// [tb/zrp_drive_model.sv]
// drive unit, switch and encoder model for the bench
`timescale 1ns/1ns
`default_nettype none
module zrp_drive_model #(
	parameter int NEAR_HI = -14,
	parameter int NEAR_LO = -22,
	parameter int LIMIT = 40
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// command pulses and contact kind
	input wire logic fwd_pulse_i,
	input wire logic rev_pulse_i,
	input wire logic [2:0] nc_i,
	// switches, zero mark, position
	output logic near_o,
	output logic fwd_lim_o,
	output logic rev_lim_o,
	output logic zero_o,
	output int pos_o
);
	logic fwd_q; // last forward level
	logic rev_q; // last reverse level
	// motor steps on pulse rising edges
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fwd_q <= 1'b0;
			rev_q <= 1'b0;
			pos_o <= 0;
		end
		else
		begin
			fwd_q <= fwd_pulse_i;
			rev_q <= rev_pulse_i;
			if (fwd_pulse_i && !fwd_q)
				pos_o <= pos_o + 1;
			else if (rev_pulse_i && !rev_q)
				pos_o <= pos_o - 1;
		end
	end
	// contacts, inverted when normally closed
	assign near_o = ((pos_o <= NEAR_HI) && (pos_o >= NEAR_LO)) ^ nc_i[zrp_pkg::POL_NEAR];
	assign fwd_lim_o = (pos_o >= LIMIT) ^ nc_i[zrp_pkg::POL_FWD];
	assign rev_lim_o = (pos_o <= -LIMIT) ^ nc_i[zrp_pkg::POL_REV];
	// zero mark every fourth step
	assign zero_o = ((pos_o & 3) == 0);
endmodule // zrp_drive_model
`default_nettype wire

// [tb/zrp_zero_return_tb_top.sv]
// self-checking bench for the zero-return pulse output block
`timescale 1ns/1ns
`default_nettype none
module zrp_zero_return_tb_top;
	logic clk_sys_i; // system clock
	logic rst_n_i; // reset, active low
	zrp_pkg::zrp_bus_s bus; // register port
	logic [31:0] rdata; // read data
	logic man, stby, intp; // mode, end standby, interpolation
	logic [3:0] req; // 1 external, 2 instruction, 3 subtask
	logic [2:0] nc; // contact kind in model
	logic near, fl, rl, zp, jog_forward_input, rev, clr, done; // pins
	int pos; // model position
	int err_count;
	int checks_done;
	logic [31:0] v; // last read
	logic ok; // clear seen
	logic [7:0] ra [7] = '{zrp_pkg::REG_CONFIG, zrp_pkg::REG_HOME_SPEED, zrp_pkg::REG_CREEP_SPEED,
		zrp_pkg::REG_ZERO_COUNT, zrp_pkg::REG_DECEL_TIME, zrp_pkg::REG_POSITION, 8'h40};
	logic [31:0] rv [7] = '{32'h41, 32'h2710, 32'h3e8, 32'h1, 32'h64, 32'h0, 32'h0};
	int ck [9] = '{1, 0, 1, 2, 3, 0, 1, 2, 3}; // source per case
	logic [8:0] cm = 9'b000011001; // manual per case
	logic [8:0] cs = 9'b001100000; // standby per case
	logic [8:0] ce = 9'b111100001; // accepted per case
	zrp_zero_return #(.TWO_AXIS(1'b1), .CLEAR_CYC(8)) zrp_zero_return_inst (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus), .rdata_o(rdata),
		.hand_operation_mode_i(man), .end_step_standby_i(stby), .home_request_input_i(req[1]),
		.home_instruction_i(req[2]), .subtask_home_request_i(req[3]), .interp_drive_i(intp),
		.near_point_switch_i(near), .forward_limit_switch_i(fl), .reverse_limit_switch_i(rl),
		.zero_point_pulse_i(zp), .fwd_pulse_o(jog_forward_input), .rev_pulse_o(rev),
		.drive_deviation_clear_output_o(clr), .home_done_flag_o(done));
	zrp_drive_model zrp_drive_model_inst (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .fwd_pulse_i(jog_forward_input), .rev_pulse_i(rev), .nc_i(nc),
		.near_o(near), .fwd_lim_o(fl), .rev_lim_o(rl), .zero_o(zp), .pos_o(pos));
	// 50 MHz clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	// verdict and end of run
	task automatic report_and_stop;
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// compare one value
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// settled point after an edge
	task automatic tk;
		@(posedge clk_sys_i);
		#1;
	endtask
	// one-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys_i);
		bus.wr <= 1'b0;
	endtask
	// one-cycle register read, data in next cycle
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys_i);
		bus.rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	// raise one home request source
	task automatic src(input int k);
		if (k == 0)
			wr(zrp_pkg::REG_CTRL, 32'h10);
		else
		begin
			@(posedge clk_sys_i);
			req[k] <= 1'b1;
			repeat (3) @(posedge clk_sys_i);
			req[k] <= 1'b0;
		end
	endtask
	// wait for clear output, bounded
	task automatic wclr(input int lim);
		ok = 1'b0;
		for (int i = 0; i < lim && !ok; i++)
		begin
			tk();
			ok = (clr === 1'b1);
		end
	endtask
	// wait for a forward level, bounded
	task automatic wt(input logic b);
		for (int i = 0; i < 3000 && jog_forward_input !== b; i++)
			tk();
	endtask
	// measure high time and period of forward pulses
	task automatic meas(input logic [31:0] hi, input logic [31:0] per);
		logic [31:0] h;
		logic [31:0] t;
		repeat (2)
		begin
			wt(1'b0);
			wt(1'b1);
		end
		h = 0;
		t = 0;
		while (jog_forward_input === 1'b1 && t < 3000)
		begin
			tk();
			h++;
			t++;
		end
		while (jog_forward_input === 1'b0 && t < 3000)
		begin
			tk();
			t++;
		end
		chk("pulse high", hi, h);
		chk("pulse period", per, t);
	endtask
	// run backwards until the model passes a point
	task automatic back_to(input int p);
		wr(zrp_pkg::REG_CTRL, 32'h2);
		for (int i = 0; i < 30000 && pos > p; i++)
			tk();
		wr(zrp_pkg::REG_CTRL, 32'h0);
		repeat (600) tk();
	endtask
	// watchdog
	initial
	begin
		#1900000;
		err_count++;
		report_and_stop();
	end
	// main sequence
	initial
	begin
		rst_n_i = 1'b0;
		bus = '0;
		man = 1'b1;
		stby = 1'b0;
		intp = 1'b0;
		req = 4'h0;
		nc = 3'h0;
		err_count = 0;
		checks_done = 0;
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		// reset values and an unmapped address
		for (int i = 0; i < 7; i++)
		begin
			rd(ra[i]);
			chk("reset value", rv[i], v);
		end
		// fast speeds, no ramp, no-switch mode
		wr(zrp_pkg::REG_HOME_SPEED, 32'h30d40);
		wr(zrp_pkg::REG_CREEP_SPEED, 32'h186a0);
		wr(zrp_pkg::REG_DECEL_TIME, 32'h0);
		wr(zrp_pkg::REG_HOME_ADDR, 32'h1234);
		wr(zrp_pkg::REG_CONFIG, 32'h45);
		// start sources against mode
		for (int i = 0; i < 9; i++)
		begin
			@(posedge clk_sys_i);
			man <= cm[i];
			stby <= cs[i];
			src(ck[i]);
			wclr(20);
			chk("accepted", ce[i], ok);
			if (ok)
			begin
				chk("done cleared", 32'h0, done);
				chk("no motion", 32'h0, pos);
				repeat (30) tk();
				chk("done set", 32'h1, done);
				rd(zrp_pkg::REG_POSITION);
				chk("home address", 32'h1234, v);
			end
			else
				chk("done kept", 32'h1, done);
		end
		// homing, leading count start
		@(posedge clk_sys_i);
		man <= 1'b1;
		stby <= 1'b0;
		wr(zrp_pkg::REG_CONFIG, 32'h41);
		src(1);
		wclr(20000);
		chk("home found", 32'h1, ok);
		chk("stop point", 32'hfffffff0, pos);
		repeat (30) tk();
		rd(zrp_pkg::REG_POSITION);
		chk("home address", 32'h1234, v);
		// pulse shape from frequency
		wr(zrp_pkg::REG_DRIVE_SPEED, 32'hc350);
		wr(zrp_pkg::REG_CTRL, 32'h1);
		meas(32'd500, 32'd1000);
		wr(zrp_pkg::REG_DRIVE_SPEED, 32'h1e848);
		meas(32'd125, 32'd400);
		@(posedge clk_sys_i);
		intp <= 1'b1;
		meas(32'd200, 32'd400);
		@(posedge clk_sys_i);
		intp <= 1'b0;
		back_to(-30);
		rd(zrp_pkg::REG_POSITION);
		chk("position", 32'h1234 + pos + 16, v);
		// search from past the switch, trailing start, closed contacts
		@(posedge clk_sys_i);
		nc <= 3'h7;
		wr(zrp_pkg::REG_CONFIG, 32'h7b);
		src(1);
		wclr(40000);
		chk("search home", 32'h1, ok);
		chk("stop point", 32'hffffffe8, pos);
		repeat (30) tk();
		// limits not wired: no search
		@(posedge clk_sys_i);
		nc <= 3'h0;
		wr(zrp_pkg::REG_CONFIG, 32'h01);
		back_to(-30);
		src(1);
		repeat (6000) tk();
		rd(zrp_pkg::REG_STATUS);
		chk("search failed", 32'h1, v[6]);
		chk("no clear", 32'h0, clr);
		chk("not done", 32'h0, done);
		// start on the near switch: move off first
		wr(zrp_pkg::REG_CTRL, 32'h1);
		for (int i = 0; i < 30000 && pos < -18; i++)
			tk();
		wr(zrp_pkg::REG_CTRL, 32'h0);
		repeat (600) tk();
		wr(zrp_pkg::REG_CONFIG, 32'h41);
		src(1);
		wclr(20000);
		chk("escape home", 32'h1, ok);
		chk("escape stop", 32'hfffffff0, pos);
		report_and_stop();
	end
endmodule // zrp_zero_return_tb_top
`default_nettype wire
